// >>> inc/ddr_cmd_if.sv
// command and read-strobe link between controller and memory device
interface ddr_cmd_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  logic odt;
  logic dqs;
  logic [15:0] dq;
  modport ctrl (
    output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
    input dqs, dq
  );
  modport dev (
    input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
    output dqs, dq
  );
endinterface : ddr_cmd_if

// >>> inc/dll_switch_pkg.sv
// constants shared by both ends of the dll-off switching link
// Operation
// - a0 of mode reg one turns dll off
// - dll bit changeable at init or later
// - controller keeps clock within dll-off limit
// - dll-off needs only cl 6, cwl 6
// - read strobe starts al+cl-1 when off
// - controller tolerates wide late strobe delay
// - controller idles device before disabling dll
// - write dll bit, wait mode-set delay
// - enter self refresh, hold clock, change
// - stable clock before self refresh exit
// - cke high until mode-set delays done
// - odt low after exit if termination on
// - rewrite latencies after self refresh exit delay
// - next command after final mode-set delay
package dll_switch_pkg;
  localparam int CLK_NS = 50;
  localparam int DLL_OFF_MAX_CLOCK_PERIOD_NS = 50;
  localparam int MODE_SET_TO_COMMAND_DELAY_NCK = 12;
  localparam int MODE_SET_TO_COMMAND_DELAY_NS = 15;
  localparam int MODE_SET_TO_COMMAND_DELAY_CYC =
    (MODE_SET_TO_COMMAND_DELAY_NCK > (MODE_SET_TO_COMMAND_DELAY_NS + CLK_NS - 1) / CLK_NS) ?
    MODE_SET_TO_COMMAND_DELAY_NCK : (MODE_SET_TO_COMMAND_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int MODE_SET_TO_MODE_SET_NCK = 4;
  localparam int PRECHARGE_NS = 14;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLOCK_HOLD_AFTER_SR_ENTRY_NS = 10;
  localparam int CLOCK_HOLD_AFTER_SR_ENTRY_CYC =
    (5 > (CLOCK_HOLD_AFTER_SR_ENTRY_NS + CLK_NS - 1) / CLK_NS) ? 5 :
    (CLOCK_HOLD_AFTER_SR_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLOCK_STABLE_BEFORE_SR_EXIT_NS = 10;
  localparam int CLOCK_STABLE_BEFORE_SR_EXIT_CYC =
    (5 > (CLOCK_STABLE_BEFORE_SR_EXIT_NS + CLK_NS - 1) / CLK_NS) ? 5 :
    (CLOCK_STABLE_BEFORE_SR_EXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SELF_REFRESH_EXIT_DELAY_NS = 270;
  localparam int SELF_REFRESH_EXIT_DELAY_CYC =
    (5 > (SELF_REFRESH_EXIT_DELAY_NS + CLK_NS - 1) / CLK_NS) ? 5 :
    (SELF_REFRESH_EXIT_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_WINDOW_CYC = 24;
  localparam int BURST_BEATS = 4;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MODE_SET = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_CAL = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESELECT = 4'h8;
  // mode register selects and fields
  localparam logic [2:0] BA_BASE_MODE_REG = 3'h0;
  localparam logic [2:0] BA_EXTENDED_MODE_REG_ONE = 3'h1;
  localparam logic [2:0] BA_EXTENDED_MODE_REG_TWO = 3'h2;
  localparam int DLL_DISABLE_BIT = 0;
  localparam int ADD_LAT_LSB = 3;
  localparam int CAS_LAT_LSB = 4;
  localparam int WRITE_RECOV_LSB = 9;
  localparam int CAS_WRITE_LAT_LSB = 3;
  localparam int PRECHARGE_ALL_BIT = 10;
  localparam logic [2:0] CAS_LAT_OFFSET = 3'h4;
  localparam logic [2:0] CAS_WRITE_LAT_OFFSET = 3'h5;
  localparam logic [2:0] CAS_LAT_6_CODE = 3'h2;
  localparam logic [2:0] CAS_WRITE_LAT_6_CODE = 3'h1;
  localparam logic [2:0] WRITE_RECOV_CODE = 3'h2;
  localparam logic [13:0] TERM_BITS_EMR1 = 14'h0244;
  localparam logic [13:0] TERM_BITS_EMR2 = 14'h0600;
  localparam logic [2:0] CAS_LAT_RESET = 3'h1;
  localparam logic [2:0] CAS_WRITE_LAT_RESET = 3'h0;
endpackage : dll_switch_pkg

// >>> logic/dram_ctrl_end.sv
// controller end: dll-on to dll-off switch sequence and read capture
module dram_ctrl_end (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  ddr_cmd_if.ctrl link,
  input wire logic start,
  input wire logic term_enabled,
  input wire logic odt_req,
  input wire logic freq_stable,
  input wire logic rd_req,
  output logic busy,
  output logic done,
  output logic freq_req,
  output logic dll_off_mode,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_timeout
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_W_PRECH = 4'h1,
    ST_W_MOD1 = 4'h3,
    ST_W_SRE = 4'h2,
    ST_FREQ = 4'h6,
    ST_W_SRX = 4'h7,
    ST_W_XS = 4'h5,
    ST_W_MRD = 4'h4,
    ST_W_MOD2 = 4'hC,
    ST_RD_WAIT = 4'hD
  } ctrl_state_e;

  typedef struct packed {
    ctrl_state_e st;
    logic [4:0] cnt;
    logic [2:0] beats;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [13:0] addr;
    logic cke;
    logic odt;
    logic freq;
    logic dll_off;
    logic done;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_timeout;
  } ctrl_state_s;

  ctrl_state_s s_q, s_d;

  // one place for command, bank and address so every issue looks alike
  function automatic logic [20:0] issue(input logic [3:0] cmd, input logic [2:0] ba,
                                        input logic [13:0] addr);
    issue = {cmd, ba, addr};
  endfunction : issue

  always_comb begin
    s_d = s_q;
    // waits drive nop only
    s_d.cmd = dll_switch_pkg::CMD_NOP;
    s_d.ba = 3'h0;
    s_d.addr = 14'h0000;
    s_d.done = 1'b0;
    s_d.rd_valid = 1'b0;
    s_d.rd_timeout = 1'b0;
    if (s_q.cnt != 5'h00) begin
      s_d.cnt = s_q.cnt - 5'h01;
    end
    // odt forced low while switching when termination was on
    s_d.odt = (s_q.st == ST_IDLE || !term_enabled) ? odt_req : 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (start) begin
          // precharge all and odt off puts the device idle first
          {s_d.cmd, s_d.ba, s_d.addr} = issue(dll_switch_pkg::CMD_PRECHARGE, 3'h0,
                                              14'(1 << dll_switch_pkg::PRECHARGE_ALL_BIT));
          s_d.odt = 1'b0;
          s_d.cnt = 5'(dll_switch_pkg::PRECHARGE_CYC - 1);
          s_d.st = ST_W_PRECH;
        end else if (rd_req) begin
          {s_d.cmd, s_d.ba, s_d.addr} = issue(dll_switch_pkg::CMD_READ, 3'h0, 14'h0000);
          s_d.cnt = 5'(dll_switch_pkg::READ_WINDOW_CYC - 1);
          s_d.beats = 3'h0;
          s_d.st = ST_RD_WAIT;
        end
      end
      ST_W_PRECH: begin
        if (s_q.cnt == 5'h00) begin
          // dll disable bit set, then mode-set delay
          {s_d.cmd, s_d.ba, s_d.addr} = issue(dll_switch_pkg::CMD_MODE_SET,
                                              dll_switch_pkg::BA_EXTENDED_MODE_REG_ONE,
                                              14'(1 << dll_switch_pkg::DLL_DISABLE_BIT));
          s_d.dll_off = 1'b1;
          s_d.cnt = 5'(dll_switch_pkg::MODE_SET_TO_COMMAND_DELAY_CYC - 1);
          s_d.st = ST_W_MOD1;
        end
      end
      ST_W_MOD1: begin
        if (s_q.cnt == 5'h00) begin
          // self refresh entry, clock held before change
          {s_d.cmd, s_d.ba, s_d.addr} = issue(dll_switch_pkg::CMD_REFRESH, 3'h0, 14'h0000);
          s_d.cke = 1'b0;
          s_d.cnt = 5'(dll_switch_pkg::CLOCK_HOLD_AFTER_SR_ENTRY_CYC - 1);
          s_d.st = ST_W_SRE;
        end
      end
      ST_W_SRE: begin
        if (s_q.cnt == 5'h00) begin
          // clock source must now move to within the dll-off period limit
          s_d.freq = 1'b1;
          s_d.st = ST_FREQ;
        end
      end
      ST_FREQ: begin
        if (freq_stable) begin
          s_d.freq = 1'b0;
          s_d.cnt = 5'(dll_switch_pkg::CLOCK_STABLE_BEFORE_SR_EXIT_CYC - 1);
          s_d.st = ST_W_SRX;
        end
      end
      ST_W_SRX: begin
        if (s_q.cnt == 5'h00) begin
          // exit only after stable-clock time
          s_d.cke = 1'b1;
          s_d.cnt = 5'(dll_switch_pkg::SELF_REFRESH_EXIT_DELAY_CYC - 1);
          s_d.st = ST_W_XS;
        end
      end
      ST_W_XS: begin
        if (s_q.cnt == 5'h00) begin
          // rewrite cas latency and write recovery after exit delay
          {s_d.cmd, s_d.ba, s_d.addr} = issue(dll_switch_pkg::CMD_MODE_SET,
              dll_switch_pkg::BA_BASE_MODE_REG,
              14'({11'h000, dll_switch_pkg::WRITE_RECOV_CODE} <<
                  dll_switch_pkg::WRITE_RECOV_LSB) |
              14'({11'h000, dll_switch_pkg::CAS_LAT_6_CODE} << dll_switch_pkg::CAS_LAT_LSB));
          s_d.cnt = 5'(dll_switch_pkg::MODE_SET_TO_MODE_SET_NCK - 1);
          s_d.st = ST_W_MRD;
        end
      end
      ST_W_MRD: begin
        if (s_q.cnt == 5'h00) begin
          // cwl 6 to match the dll-off latency pair
          {s_d.cmd, s_d.ba, s_d.addr} = issue(dll_switch_pkg::CMD_MODE_SET,
              dll_switch_pkg::BA_EXTENDED_MODE_REG_TWO,
              14'({11'h000, dll_switch_pkg::CAS_WRITE_LAT_6_CODE} <<
                  dll_switch_pkg::CAS_WRITE_LAT_LSB));
          s_d.cnt = 5'(dll_switch_pkg::MODE_SET_TO_COMMAND_DELAY_CYC - 1);
          s_d.st = ST_W_MOD2;
        end
      end
      ST_W_MOD2: begin
        // cke stays high through here
        if (s_q.cnt == 5'h00) begin
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      ST_RD_WAIT: begin
        // strobe-timed capture, no fixed latency assumed
        if (link.dqs) begin
          s_d.rd_data = link.dq;
          s_d.rd_valid = 1'b1;
          s_d.beats = s_q.beats + 3'h1;
          if (s_q.beats == 3'(dll_switch_pkg::BURST_BEATS - 1)) begin
            s_d.st = ST_IDLE;
          end
        end else if (s_q.cnt == 5'h00) begin
          s_d.rd_timeout = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: ST_IDLE, cnt: 5'h00, beats: 3'h0, cmd: dll_switch_pkg::CMD_NOP,
               ba: 3'h0, addr: 14'h0000, cke: 1'b1, odt: 1'b0, freq: 1'b0,
               dll_off: 1'b0, done: 1'b0, rd_data: 16'h0000, rd_valid: 1'b0,
               rd_timeout: 1'b0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign link.cke = s_q.cke;
  assign link.cs_n = s_q.cmd[3];
  assign link.ras_n = s_q.cmd[2];
  assign link.cas_n = s_q.cmd[1];
  assign link.we_n = s_q.cmd[0];
  assign link.ba = s_q.ba;
  assign link.addr = s_q.addr;
  assign link.odt = s_q.odt;
  assign busy = s_q.st != ST_IDLE;
  assign done = s_q.done;
  assign freq_req = s_q.freq;
  assign dll_off_mode = s_q.dll_off;
  assign rd_data = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;
  assign rd_timeout = s_q.rd_timeout;
endmodule : dram_ctrl_end

// >>> logic/dram_dev_end.sv
// memory device end: mode registers, dll-off state, read strobe timing
module dram_dev_end (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  ddr_cmd_if.dev link,
  input wire logic [15:0] rd_word,
  output logic dll_off,
  output logic [4:0] cas_latency,
  output logic [4:0] cas_write_latency,
  output logic self_refresh,
  output logic cmd_ready,
  output logic latency_bad,
  output logic cmd_early
);
  typedef struct packed {
    logic dll_off;
    logic [1:0] add_lat;
    logic [2:0] cl_code;
    logic [2:0] cwl_code;
    logic sr;
    logic [4:0] mod_cnt;
    logic rd_pend;
    logic [4:0] rd_cnt;
    logic [2:0] beat;
    logic dqs;
    logic [15:0] dq;
    logic early;
  } dev_state_s;

  dev_state_s s_q, s_d;

  function automatic logic [3:0] cmd_of(input logic cs_n, input logic ras_n,
                                        input logic cas_n, input logic we_n);
    cmd_of = cs_n ? dll_switch_pkg::CMD_DESELECT : {1'b0, ras_n, cas_n, we_n};
  endfunction : cmd_of

  logic [3:0] cmd;
  logic [4:0] cl_val;
  logic [4:0] al_val;
  logic [4:0] rd_delay;

  always_comb begin
    cmd = cmd_of(link.cs_n, link.ras_n, link.cas_n, link.we_n);
    cl_val = {2'h0, s_q.cl_code + dll_switch_pkg::CAS_LAT_OFFSET};
    case (s_q.add_lat)
      2'h1: al_val = cl_val - 5'h01;
      2'h2: al_val = cl_val - 5'h02;
      default: al_val = 5'h00;
    endcase
    // strobe launched one edge earlier with the dll off
    rd_delay = al_val + cl_val - {4'h0, s_q.dll_off};
  end

  always_comb begin
    s_d = s_q;
    s_d.early = 1'b0;
    if (s_q.mod_cnt != 5'h00) begin
      s_d.mod_cnt = s_q.mod_cnt - 5'h01;
    end
    if (s_q.rd_pend) begin
      if (s_q.rd_cnt == 5'h00) begin
        s_d.rd_pend = 1'b0;
        s_d.dqs = 1'b1;
        s_d.dq = rd_word;
        s_d.beat = 3'(dll_switch_pkg::BURST_BEATS - 1);
      end else begin
        s_d.rd_cnt = s_q.rd_cnt - 5'h01;
      end
    end else if (s_q.beat != 3'h0) begin
      s_d.beat = s_q.beat - 3'h1;
      s_d.dq = rd_word;
    end else begin
      s_d.dqs = 1'b0;
    end
    if (s_q.sr) begin
      // commands are ignored until cke returns high
      if (link.cke) begin
        s_d.sr = 1'b0;
      end
    end else if (cmd == dll_switch_pkg::CMD_REFRESH && !link.cke) begin
      s_d.sr = 1'b1;
    end else if (cmd == dll_switch_pkg::CMD_MODE_SET) begin
      // mode sets taken at any idle point, init or later
      s_d.mod_cnt = 5'(dll_switch_pkg::MODE_SET_TO_COMMAND_DELAY_CYC);
      case (link.ba)
        dll_switch_pkg::BA_EXTENDED_MODE_REG_ONE: begin
          s_d.dll_off = link.addr[dll_switch_pkg::DLL_DISABLE_BIT];
          s_d.add_lat = link.addr[dll_switch_pkg::ADD_LAT_LSB +: 2];
        end
        dll_switch_pkg::BA_BASE_MODE_REG: begin
          s_d.cl_code = link.addr[dll_switch_pkg::CAS_LAT_LSB +: 3];
        end
        dll_switch_pkg::BA_EXTENDED_MODE_REG_TWO: begin
          s_d.cwl_code = link.addr[dll_switch_pkg::CAS_WRITE_LAT_LSB +: 3];
        end
        default: begin
        end
      endcase
    end else if (cmd != dll_switch_pkg::CMD_NOP && cmd != dll_switch_pkg::CMD_DESELECT) begin
      if (s_q.mod_cnt != 5'h00) begin
        // too early after a mode set: dropped, flagged
        s_d.early = 1'b1;
      end else if (cmd == dll_switch_pkg::CMD_READ && !s_q.rd_pend && s_q.beat == 3'h0) begin
        s_d.rd_pend = 1'b1;
        s_d.rd_cnt = rd_delay - 5'h02;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{dll_off: 1'b0, add_lat: 2'h0, cl_code: dll_switch_pkg::CAS_LAT_RESET,
               cwl_code: dll_switch_pkg::CAS_WRITE_LAT_RESET, sr: 1'b0, mod_cnt: 5'h00,
               rd_pend: 1'b0, rd_cnt: 5'h00, beat: 3'h0, dqs: 1'b0, dq: 16'h0000,
               early: 1'b0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign link.dqs = s_q.dqs;
  assign link.dq = s_q.dq;
  assign dll_off = s_q.dll_off;
  assign cas_latency = {2'h0, s_q.cl_code + dll_switch_pkg::CAS_LAT_OFFSET};
  assign cas_write_latency = {2'h0, s_q.cwl_code + dll_switch_pkg::CAS_WRITE_LAT_OFFSET};
  assign self_refresh = s_q.sr;
  assign cmd_ready = !s_q.sr && s_q.mod_cnt == 5'h00;
  // only cl 6 / cwl 6 supported with the dll off
  assign latency_bad = s_q.dll_off && (s_q.cl_code != dll_switch_pkg::CAS_LAT_6_CODE ||
                       s_q.cwl_code != dll_switch_pkg::CAS_WRITE_LAT_6_CODE);
  assign cmd_early = s_q.early;
endmodule : dram_dev_end

// >>> tb/dll_switch_props.sv
// checker on the command link between controller and device ends
module dll_switch_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic odt,
  input wire logic dqs,
  input wire logic [15:0] dq
);
  logic [3:0] cmd;
  logic idle;
  logic mrs1;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign idle = cs_n || (cmd == dll_switch_pkg::CMD_NOP);
  assign mrs1 = (cmd == dll_switch_pkg::CMD_MODE_SET) && (ba == 3'h1);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_pre_first;
    mrs1 |-> $past(cmd) == dll_switch_pkg::CMD_PRECHARGE && $past(addr[10]);
  endproperty
  a_pre_first: assert property (p_pre_first) else $error("dll write not after precharge all");
  property p_dll_bit;
    mrs1 |-> addr[0];
  endproperty
  a_dll_bit: assert property (p_dll_bit) else $error("dll disable bit not set");
  property p_mod_wait;
    mrs1 |=> idle[*8] ##1 idle[*3] ##1 (cmd == dll_switch_pkg::CMD_REFRESH && !cke);
  endproperty
  a_mod_wait: assert property (p_mod_wait) else $error("self refresh entry not 12 after mode set");
  property p_sre_hold;
    $fell(cke) |=> (!cke && idle)[*5];
  endproperty
  a_sre_hold: assert property (p_sre_hold) else $error("clock enable rose too soon");
  // 23 cycles covers exit delay, both mode writes and the final delay
  property p_cke_high;
    $rose(cke) |-> cke[*8] ##1 cke[*8] ##1 cke[*7];
  endproperty
  a_cke_high: assert property (p_cke_high) else $error("clock enable dropped after exit");
  property p_xs_mrs0;
    $rose(cke) |-> idle[*6] ##1 (cmd == dll_switch_pkg::CMD_MODE_SET && ba == 3'h0
      && addr[6:4] == 3'h2 && addr[11:9] == 3'h2);
  endproperty
  a_xs_mrs0: assert property (p_xs_mrs0) else $error("latency write not after exit delay");
  property p_mrd_mrs2;
    (cmd == dll_switch_pkg::CMD_MODE_SET && ba == 3'h0) |=> idle[*3] ##1
      (cmd == dll_switch_pkg::CMD_MODE_SET && ba == 3'h2 && addr[5:3] == 3'h1);
  endproperty
  a_mrd_mrs2: assert property (p_mrd_mrs2) else $error("write latency not set 4 later");
  property p_final_wait;
    (cmd == dll_switch_pkg::CMD_MODE_SET && ba == 3'h2) |=> idle[*8] ##1 idle[*3];
  endproperty
  a_final_wait: assert property (p_final_wait) else $error("command inside final delay");
  property p_read_strobe;
    (cmd == dll_switch_pkg::CMD_READ) |=> !dqs[*4] ##1 dqs[*4] ##1 !dqs;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe at wrong cycle");
  c_read: cover property (cmd == dll_switch_pkg::CMD_READ);
  c_sre: cover property ($fell(cke));
  c_mrs2: cover property (cmd == dll_switch_pkg::CMD_MODE_SET && ba == 3'h2);
endmodule : dll_switch_props

// >>> tb/tb_top.sv
// self-checking bench joining controller and device ends
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [15:0] word; logic [15:0] lat;} row_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic term_enabled = 1'b1;
  logic odt_req = 1'b1;
  logic freq_stable = 1'b0;
  logic rd_req = 1'b0;
  logic [15:0] rd_word = 16'h0000;
  logic dll_off, self_refresh, cmd_ready, latency_bad, cmd_early;
  logic [4:0] cas_latency, cas_write_latency;
  logic busy, done, freq_req, dll_off_mode, rd_valid, rd_timeout;
  logic [15:0] rd_data;
  int error_cnt = 0;
  int compares = 0;
  int n;
  // first beat seven edges after request: dll-off drops one cycle but cl rises one
  row_s rows [4] = '{'{16'hA5C3, 16'h0007}, '{16'h0000, 16'h0007},
    '{16'hFFFF, 16'h0007}, '{16'h1234, 16'h0007}};
  ddr_cmd_if link_if ();
  dram_dev_end i_dram_dev_end (.clk(clk), .rstn(rstn), .ce(ce), .link(link_if.dev),
    .rd_word(rd_word), .dll_off(dll_off), .cas_latency(cas_latency),
    .cas_write_latency(cas_write_latency), .self_refresh(self_refresh),
    .cmd_ready(cmd_ready), .latency_bad(latency_bad), .cmd_early(cmd_early));
  dram_ctrl_end i_dram_ctrl_end (.clk(clk), .rstn(rstn), .ce(ce), .link(link_if.ctrl),
    .start(start), .term_enabled(term_enabled), .odt_req(odt_req),
    .freq_stable(freq_stable), .rd_req(rd_req), .busy(busy), .done(done),
    .freq_req(freq_req), .dll_off_mode(dll_off_mode), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_timeout(rd_timeout));
  dll_switch_props i_dll_switch_props (.clk(clk), .rstn(rstn), .cke(link_if.cke),
    .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
    .we_n(link_if.we_n), .ba(link_if.ba), .addr(link_if.addr), .odt(link_if.odt),
    .dqs(link_if.dqs), .dq(link_if.dq));
  always #25 clk = ~clk;
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task test_done();
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task cyc();
    @(posedge clk);
    #5;
  endtask : cyc
  task do_read(input row_s r);
    int k;
    int beats;
    rd_word = r.word;
    rd_req = 1'b1;
    k = 0;
    beats = 0;
    while (beats < 4 && k < 40) begin
      cyc();
      k++;
      rd_req = 1'b0;
      if (rd_timeout === 1'b1) chk("read timeout", 16'h0000, 16'h0001);
      if (rd_valid === 1'b1) begin
        if (beats == 0) chk("read latency", r.lat, 16'(k));
        chk("read data", r.word, rd_data);
        beats++;
      end
    end
    chk("read beats", 16'h0004, 16'(beats));
    cyc();
  endtask : do_read
  initial begin
    #(50 * 4000);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (9) @(posedge clk);
    #5;
    chk("reset cke", 16'h0001, {15'h0000, link_if.cke});
    chk("reset dll", 16'h0000, {15'h0000, dll_off});
    chk("reset cl", 16'h0005, {11'h000, cas_latency});
    chk("reset cwl", 16'h0005, {11'h000, cas_write_latency});
    chk("reset busy", 16'h0000, {15'h0000, busy});
    @(posedge clk);
    #5;
    rstn = 1'b1;
    cyc();
    foreach (rows[i]) do_read(rows[i]);
    start = 1'b1;
    cyc();
    start = 1'b0;
    chk("busy", 16'h0001, {15'h0000, busy});
    n = 0;
    while (freq_req !== 1'b1 && n < 100) begin
      rd_req = (n == 3); // refused while busy
      start = (n == 3);
      cyc();
      n++;
      chk("odt low", 16'h0000, {15'h0000, link_if.odt});
      if ({link_if.cs_n, link_if.ras_n, link_if.cas_n, link_if.we_n} === 4'h5)
        chk("read while busy", 16'h0000, 16'h0001);
    end
    rd_req = 1'b0;
    start = 1'b0;
    chk("dll off", 16'h0001, {15'h0000, dll_off});
    chk("self refresh", 16'h0001, {15'h0000, self_refresh});
    repeat (20) cyc();
    chk("cke held low", 16'h0000, {15'h0000, link_if.cke});
    freq_stable = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      cyc();
      n++;
      chk("odt low", 16'h0000, {15'h0000, link_if.odt});
    end
    freq_stable = 1'b0;
    chk("done", 16'h0001, {15'h0000, done});
    chk("mode flag", 16'h0001, {15'h0000, dll_off_mode});
    chk("cl", 16'h0006, {11'h000, cas_latency});
    chk("cwl", 16'h0006, {11'h000, cas_write_latency});
    chk("latency bad", 16'h0000, {15'h0000, latency_bad});
    cyc();
    chk("ready", 16'h0001, {15'h0000, cmd_ready});
    chk("freq req", 16'h0000, {15'h0000, freq_req});
    chk("odt idle", 16'h0001, {15'h0000, link_if.odt});
    chk("dropped", 16'h0000, {15'h0000, cmd_early});
    foreach (rows[i]) do_read(rows[i]);
    ce = 1'b0;
    rd_req = 1'b1;
    repeat (3) cyc();
    chk("frozen busy", 16'h0000, {15'h0000, busy});
    rd_req = 1'b0;
    ce = 1'b1;
    cyc();
    chk("frozen read", 16'h0000, {15'h0000, busy});
    test_done();
  end
endmodule : tb_top
